// >>> rth_pkg.sv
/*
 * shared constants and carrier types for the reload timer, interrupt
 * enable and hold/stop control block.
 * assumes a single system clock and instruction strobes from the core.
 */
package rth_pkg;

    localparam int unsigned TMR_W          = 8;            // counter and reload width
    localparam int unsigned PRESC_W        = 6;            // prescaler width
    localparam int unsigned PRESC_DIV_DEF  = 64;           // slow clock divisor

    // timer mode control fields
    localparam int unsigned MODE_SLOW_BIT  = 0;            // 1 selects divided clock
    localparam int unsigned MODE_TONE_BIT  = 2;            // 1 routes timer to tone pin
    localparam int unsigned MODE_RUN_BIT   = 3;            // 1 runs the counter
    localparam logic [3:0]  MODE_RST       = 4'h0;

    // event, enable and cause bit positions
    localparam int unsigned EV_DIV_BIT     = 0;
    localparam int unsigned EV_PORT_BIT    = 2;
    localparam int unsigned EV_TMR_BIT     = 7;
    localparam int unsigned CAUSE_TMR_BIT  = 5;            // timer cause sits lower
    localparam logic [7:0]  FLAG8_RST      = 8'h00;
    localparam logic [3:0]  FLAG4_RST      = 4'h0;

    // fixed service vectors, in priority order
    localparam logic [10:0] VEC_DIV        = 11'h004;
    localparam logic [10:0] VEC_PORT       = 11'h00C;
    localparam logic [10:0] VEC_TMR        = 11'h020;
    localparam logic [10:0] VEC_NONE       = 11'h000;

    // one-cycle instruction strobes from the core, same clock
    typedef struct packed {
        logic       wr_reload_low;   // store low reload nibble
        logic       wr_reload_high;  // store high reload nibble
        logic       wr_mode;         // write timer_mode_control
        logic       wr_hef;          // write hold_release_enable_mask
        logic       wr_ief;          // write interrupt_enable_mask
        logic       wr_pef;          // write port_change_enable
        logic       wr_wake_en;      // write stop wake enable
        logic       clr_evf;         // clear event_flags by mask
        logic       en_int;          // enable-all instruction
        logic       irq_disable_all_instr;         // irq_disable_all_instr
        logic       hold;            // hold instruction
        logic       stop;            // stop instruction
        logic       int_ack;         // core takes the pending request
        logic [7:0] data;            // immediate / register data
    } rth_instr_t;

    // whole state of the block
    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic [TMR_W-1:0]   cnt;
        logic [TMR_W-1:0]   reload;
        logic [3:0]         mode;
        logic [7:0]         event_flags;
        logic [7:0]         interrupt_enable_mask;
        logic [7:0]         hold_release_enable_mask;
        logic [7:0]         hold_release_cause;
        logic [3:0]         port_change_enable;
        logic [3:0]         wake_en;
        logic               inhibit;
        logic               hold;
        logic               stop;
        logic               tone;
        logic               tone_pin;
        logic               push;
        logic [3:0]         wk_s1;
        logic [3:0]         wk_s2;
        logic [3:0]         wk_s3;
    } rth_state_t;

endpackage : rth_pkg

// >>> rth_reload_timer_irq_hold_ctrl.sv
/*
 * reload down timer with prescale, tone output routing, event flags,
 * interrupt enable/priority logic and hold/stop power-mode control.
 * assumes instruction strobes and event pulses arrive on i_core_clk and
 * the wake pins are asynchronous; the clock is kept alive for wake-up.
 */
`timescale 1ns/1ps

module rth_reload_timer_irq_hold_ctrl
    import rth_pkg::*;
#(
    parameter int unsigned PRESC_DIV = PRESC_DIV_DEF    // slow clock divisor
)(
    input  wire logic        i_core_clk,                // system clock
    input  wire logic        i_sys_rst,                 // async reset, high
    input  wire rth_instr_t  i_instr,                   // instruction strobes
    input  wire logic        i_div_ovf,                 // divider overflow pulse
    input  wire logic [3:0]  i_port_change,             // per-pin change pulses
    input  wire logic [3:0]  i_wake_input_port,         // async wake pins
    input  wire logic        i_tone_gen_wave,           // separate generator wave
    output logic             o_tone_output_pin,         // tone pin, registered
    output logic [7:0]       o_event_flags,             // event flags
    output logic [7:0]       o_hold_release_cause,      // hold release cause
    output logic             o_irq_req,                 // request to core
    output logic [10:0]      o_irq_vector,              // vector of request
    output logic             o_stack_push,              // push pc pulse
    output logic             o_hold,                    // execution held
    output logic             o_stop                     // oscillator stopped
);

    // refuse divisors the 6-bit prescaler cannot count
    if (PRESC_DIV < 2 || PRESC_DIV > (1 << PRESC_W))
    begin : g_bad_div
        $error("prescale divisor out of range");
    end

    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);

    rth_state_t s_q;                                     // registered state
    rth_state_t s_d;                                     // next state
    logic       tick;                                    // counter enable
    logic       underflow;                               // counter passes zero
    logic [7:0] ev_set;                                  // hardware set pulses
    logic [2:0] pend;                                    // enabled requests
    logic [3:0] wake_fall;                               // synced falling edges

    // fixed vector per source, first pending wins
    function automatic logic [10:0] pick_vec(input logic [2:0] p);
        logic [10:0] v;
        v = VEC_NONE;
        if (p[0])
        begin
            v = VEC_DIV;
        end
        else if (p[1])
        begin
            v = VEC_PORT;
        end
        else if (p[2])
        begin
            v = VEC_TMR;
        end
        return v;
    endfunction : pick_vec

    // one-hot event bit of the chosen source
    function automatic logic [7:0] pick_bit(input logic [2:0] p);
        logic [7:0] b;
        b = 8'h00;
        if (p[0])
        begin
            b[EV_DIV_BIT] = 1'b1;
        end
        else if (p[1])
        begin
            b[EV_PORT_BIT] = 1'b1;
        end
        else if (p[2])
        begin
            b[EV_TMR_BIT] = 1'b1;
        end
        return b;
    endfunction : pick_bit

    // combinational view shared by next state and outputs
    always_comb
    begin
        // fast clock every edge, slow clock on prescaler wrap
        tick      = s_q.mode[MODE_SLOW_BIT] ? (s_q.presc == PRESC_LAST) : 1'b1;
        underflow = s_q.mode[MODE_RUN_BIT] && tick && (s_q.cnt == '0);
        ev_set    = 8'h00;
        ev_set[EV_DIV_BIT]  = i_div_ovf;
        ev_set[EV_PORT_BIT] = |(i_port_change & s_q.port_change_enable);
        ev_set[EV_TMR_BIT]  = underflow;
        // enabled requests; port flag already qualified by port enable
        pend[0] = s_q.event_flags[EV_DIV_BIT]  & s_q.interrupt_enable_mask[EV_DIV_BIT];
        pend[1] = s_q.event_flags[EV_PORT_BIT] & s_q.interrupt_enable_mask[EV_PORT_BIT];
        pend[2] = s_q.event_flags[EV_TMR_BIT]  & s_q.interrupt_enable_mask[EV_TMR_BIT];
        // second and third stages only; first stage feeds nothing else
        wake_fall = s_q.wk_s3 & ~s_q.wk_s2 & s_q.wake_en;
    end

    // next state
    always_comb
    begin
        logic [7:0] clr;
        logic [7:0] rel;
        clr  = 8'h00;
        rel  = 8'h00;
        s_d  = s_q;
        s_d.push  = 1'b0;
        s_d.wk_s1 = i_wake_input_port;
        s_d.wk_s2 = s_q.wk_s1;
        s_d.wk_s3 = s_q.wk_s2;

        // prescaler wraps at the divisor so a short divisor still ticks evenly
        s_d.presc = (s_q.presc == PRESC_LAST) ? '0 : s_q.presc + 1'b1;

        // counter: decrement, or reload on passing zero
        if (underflow)
        begin
            s_d.cnt  = s_q.reload;
            s_d.tone = ~s_q.tone;
        end
        else if (s_q.mode[MODE_RUN_BIT] && tick)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end

        // reload nibble writes halt the counter
        if (i_instr.wr_reload_low)
        begin
            s_d.reload[3:0]         = i_instr.data[3:0];
            s_d.mode[MODE_RUN_BIT]  = 1'b0;
        end
        if (i_instr.wr_reload_high)
        begin
            s_d.reload[7:4]         = i_instr.data[3:0];
            s_d.mode[MODE_RUN_BIT]  = 1'b0;
        end

        // mode write; bit 1 is kept as written but drives nothing
        if (i_instr.wr_mode)
        begin
            s_d.mode = i_instr.data[3:0];
            if (i_instr.data[MODE_RUN_BIT])
            begin
                s_d.cnt   = s_q.reload;
                s_d.presc = '0;
                clr[EV_TMR_BIT] = 1'b1;
            end
        end

        // write-only masks
        if (i_instr.wr_hef)
        begin
            s_d.hold_release_enable_mask = i_instr.data;
        end
        if (i_instr.wr_ief)
        begin
            s_d.interrupt_enable_mask = i_instr.data;
        end
        if (i_instr.wr_pef)
        begin
            s_d.port_change_enable = i_instr.data[3:0];
        end
        if (i_instr.wr_wake_en)
        begin
            s_d.wake_en = i_instr.data[3:0];
        end

        // interrupt acceptance clears only the served flag
        if (i_instr.int_ack && o_irq_req)
        begin
            clr    = clr | pick_bit(pend);
            s_d.push = 1'b1;
        end
        if (i_instr.clr_evf)
        begin
            clr = clr | i_instr.data;
        end

        // sticky flags; a set in the same cycle beats any clear
        s_d.event_flags = (s_q.event_flags & ~clr) | ev_set;

        // inhibit after acceptance or disable-all; enable-all or mask write lifts it
        if (i_instr.int_ack && o_irq_req)
        begin
            s_d.inhibit = 1'b1;
        end
        else if (i_instr.irq_disable_all_instr)
        begin
            s_d.inhibit = 1'b1;
        end
        else if (i_instr.en_int || i_instr.wr_ief)
        begin
            s_d.inhibit = 1'b0;
        end

        // release causes: flag clear or mask bit cleared drops the cause
        rel[EV_DIV_BIT]    = ev_set[EV_DIV_BIT]  & s_q.hold_release_enable_mask[EV_DIV_BIT];
        rel[EV_PORT_BIT]   = ev_set[EV_PORT_BIT] & s_q.hold_release_enable_mask[EV_PORT_BIT];
        rel[CAUSE_TMR_BIT] = ev_set[EV_TMR_BIT]  & s_q.hold_release_enable_mask[EV_TMR_BIT];
        s_d.hold_release_cause = s_q.hold_release_cause;
        s_d.hold_release_cause[EV_DIV_BIT]    = s_q.hold_release_cause[EV_DIV_BIT]
                                 & ~clr[EV_DIV_BIT] & s_d.hold_release_enable_mask[EV_DIV_BIT];
        s_d.hold_release_cause[EV_PORT_BIT]   = s_q.hold_release_cause[EV_PORT_BIT]
                                 & ~clr[EV_PORT_BIT] & s_d.hold_release_enable_mask[EV_PORT_BIT];
        s_d.hold_release_cause[CAUSE_TMR_BIT] = s_q.hold_release_cause[CAUSE_TMR_BIT]
                                 & ~clr[EV_TMR_BIT] & s_d.hold_release_enable_mask[EV_TMR_BIT];
        if (s_q.hold)
        begin
            s_d.hold_release_cause = s_d.hold_release_cause | rel;
        end

        // hold: timers keep running, only execution stops
        if (s_q.hold)
        begin
            if ((|rel) || o_irq_req)
            begin
                s_d.hold = 1'b0;
            end
        end
        else if (i_instr.hold && (s_q.hold_release_cause == 8'h00))
        begin
            s_d.hold = 1'b1;
        end

        // stop: only an enabled falling wake edge ends it
        if (s_q.stop)
        begin
            if (|wake_fall)
            begin
                s_d.stop = 1'b0;
            end
        end
        else if (i_instr.stop)
        begin
            s_d.stop = 1'b1;
        end

        // tone pin source select, registered so the pin never glitches
        s_d.tone_pin = s_q.mode[MODE_TONE_BIT] ? s_q.tone : i_tone_gen_wave;
    end

    // state register; constants only under reset
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            s_q <= '{presc: '0, cnt: '0, reload: '0, mode: MODE_RST,
                     event_flags: FLAG8_RST, interrupt_enable_mask: FLAG8_RST, hold_release_enable_mask: FLAG8_RST,
                     hold_release_cause: FLAG8_RST, port_change_enable: FLAG4_RST, wake_en: FLAG4_RST,
                     inhibit: 1'b0, hold: 1'b0, stop: 1'b0, tone: 1'b0,
                     tone_pin: 1'b0, push: 1'b0, wk_s1: 4'hF, wk_s2: 4'hF,
                     wk_s3: 4'hF};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs; request is a combinational handshake term
    assign o_irq_req            = (|pend) && !s_q.inhibit;
    assign o_irq_vector         = pick_vec(pend);
    assign o_tone_output_pin    = s_q.tone_pin;
    assign o_event_flags        = s_q.event_flags;
    assign o_hold_release_cause = s_q.hold_release_cause;
    assign o_stack_push         = s_q.push;
    assign o_hold               = s_q.hold;
    assign o_stop               = s_q.stop;

    // named steps of a timer pass
    sequence s_underflow;
        s_q.mode[MODE_RUN_BIT] && tick && (s_q.cnt == '0) && !i_instr.wr_mode
        && !i_instr.wr_reload_low && !i_instr.wr_reload_high;
    endsequence
    sequence s_reloaded;
        (s_q.cnt == $past(s_q.reload)) && s_q.event_flags[EV_TMR_BIT];
    endsequence

    property p_underflow_reload;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_underflow |=> s_reloaded;
    endproperty
    a_underflow_reload: assert property (p_underflow_reload) else $error("no reload on underflow");

    property p_nibble_halts;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_instr.wr_reload_low || i_instr.wr_reload_high) && !i_instr.wr_mode
        |=> !s_q.mode[MODE_RUN_BIT] ##1 ($stable(s_q.cnt) || $past(i_instr.wr_mode));
    endproperty
    a_nibble_halts: assert property (p_nibble_halts) else $error("reload write did not halt");

    property p_run_loads;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_instr.wr_mode && i_instr.data[MODE_RUN_BIT] && !underflow
        |=> (s_q.cnt == $past(s_q.reload)) && !s_q.event_flags[EV_TMR_BIT];
    endproperty
    a_run_loads: assert property (p_run_loads) else $error("run set did not load");

    property p_fast_dec;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.mode[MODE_RUN_BIT] && !s_q.mode[MODE_SLOW_BIT] && (s_q.cnt != '0)
        && !i_instr.wr_mode && !i_instr.wr_reload_low && !i_instr.wr_reload_high
        |=> s_q.cnt == $past(s_q.cnt) - 1'b1;
    endproperty
    a_fast_dec: assert property (p_fast_dec) else $error("fast clock did not decrement");

    property p_slow_holds;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.mode[MODE_SLOW_BIT] && (s_q.presc != PRESC_LAST) && !i_instr.wr_mode
        && !i_instr.wr_reload_low && !i_instr.wr_reload_high
        |=> $stable(s_q.cnt);
    endproperty
    a_slow_holds: assert property (p_slow_holds) else $error("slow clock counted early");

    property p_vec_priority;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_irq_req && pend[0] |-> o_irq_vector == VEC_DIV;
    endproperty
    a_vec_priority: assert property (p_vec_priority) else $error("divider not served first");

    property p_ack_inhibit;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_irq_req && i_instr.int_ack && !i_instr.en_int && !i_instr.wr_ief
        |=> o_stack_push && !o_irq_req;
    endproperty
    a_ack_inhibit: assert property (p_ack_inhibit) else $error("taken request not inhibited");

    property p_hold_refused;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !s_q.hold && i_instr.hold && (s_q.hold_release_cause != 8'h00) |=> !o_hold;
    endproperty
    a_hold_refused: assert property (p_hold_refused) else $error("hold taken with cause set");

    property p_tone_route;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.mode[MODE_TONE_BIT] |=> o_tone_output_pin == $past(s_q.tone);
    endproperty
    a_tone_route: assert property (p_tone_route) else $error("tone pin not from timer");

    property p_flag_sticky;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_q.event_flags[EV_TMR_BIT] && !i_instr.clr_evf && !i_instr.int_ack && !i_instr.wr_mode
        |=> s_q.event_flags[EV_TMR_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("timer flag lost");

endmodule : rth_reload_timer_irq_hold_ctrl

// >>> rth_reload_timer_irq_hold_ctrl_tb_top.sv
/*
 * self-checking bench for the reload timer, interrupt and hold/stop block.
 * assumes the design is built with a short prescale divisor of 4 and that
 * inputs change 2 ns after each rising edge of the 50 ns clock.
 */
`timescale 1ns/1ps

module rth_reload_timer_irq_hold_ctrl_tb_top;
    import rth_pkg::*;

    localparam int DIV = 4;                 // short prescale keeps the run brief
    localparam int K_LO = 0, K_HI = 1, K_MODE = 2, K_HEF = 3, K_IEF = 4, K_PEF = 5;
    localparam int K_WAKE = 6, K_CLR = 7, K_EN = 8, K_DIS = 9, K_HOLD = 10, K_STOP = 11;
    localparam int K_ACK = 12;

    logic        clk;                       // system clock
    logic        rst;                       // async reset, high
    rth_instr_t  instr;                     // instruction strobes
    logic        div_ovf;                   // divider overflow pulse
    logic [3:0]  port_chg;                  // port change pulses
    logic [3:0]  wake_pins;                 // from the wake model
    logic [3:0]  fall_req;                  // bench request to the wake model
    logic        tone_wave;                 // separate generator waveform
    logic        pin;                       // tone output pin
    logic [7:0]  event_flags;                       // event flags
    logic [7:0]  hold_release_cause;                       // hold release cause
    logic        irq;                       // interrupt request
    logic [10:0] vec;                       // interrupt vector
    logic        push;                      // stack push pulse
    logic        hold;                      // hold state
    logic        stop;                      // stop state
    int          failures;                  // mismatches seen
    int          comparisons;               // checks made
    int          n;                         // measured cycle count

    rth_reload_timer_irq_hold_ctrl #(.PRESC_DIV(DIV)) uut (
        .i_core_clk           (clk),
        .i_sys_rst            (rst),
        .i_instr              (instr),
        .i_div_ovf            (div_ovf),
        .i_port_change        (port_chg),
        .i_wake_input_port    (wake_pins),
        .i_tone_gen_wave      (tone_wave),
        .o_tone_output_pin    (pin),
        .o_event_flags        (event_flags),
        .o_hold_release_cause (hold_release_cause),
        .o_irq_req            (irq),
        .o_irq_vector         (vec),
        .o_stack_push         (push),
        .o_hold               (hold),
        .o_stop               (stop)
    );

    rth_wake_model partner (
        .i_clk       (clk),
        .i_fall_req  (fall_req),
        .o_wake_pins (wake_pins)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // one compare task for single flags, one for wider values
    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_val(input string what, input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    // one instruction strobe for exactly one cycle; raised 2 ns after an edge and
    // dropped on the taking edge itself, so back-to-back calls never write twice at once
    task automatic op(input int k, input logic [7:0] d);
        rth_instr_t s;
        s = '0;
        s.data = d;
        case (k)
            K_LO:    s.wr_reload_low = 1'b1;
            K_HI:    s.wr_reload_high = 1'b1;
            K_MODE:  s.wr_mode = 1'b1;
            K_HEF:   s.wr_hef = 1'b1;
            K_IEF:   s.wr_ief = 1'b1;
            K_PEF:   s.wr_pef = 1'b1;
            K_WAKE:  s.wr_wake_en = 1'b1;
            K_CLR:   s.clr_evf = 1'b1;
            K_EN:    s.en_int = 1'b1;
            K_DIS:   s.irq_disable_all_instr = 1'b1;
            K_HOLD:  s.hold = 1'b1;
            K_STOP:  s.stop = 1'b1;
            default: s.int_ack = 1'b1;
        endcase
        instr = s;
        @(posedge clk);
        instr <= '0;
        #2;
    endtask : op

    // cycles until the tone pin changes, capped so a dead pin cannot hang
    task automatic tone_gap(input int lim, output int cnt);
        logic v;
        v = pin;
        cnt = 0;
        while (pin === v && cnt < lim)
        begin
            @(posedge clk);
            #2 cnt++;
        end
    endtask : tone_gap

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask : cyc

    // reset state: nothing pending, pin low, hold not taken
    task automatic t_reset;
        chk_val("event flags", 11'h000, {3'b0, event_flags});
        chk_bit("tone pin", 1'b0, pin);
        chk_bit("irq", 1'b0, irq);
        chk_bit("hold", 1'b0, hold);
    endtask : t_reset

    // preset 2 gives a toggle every 3 fast ticks and 12 slow cycles
    task automatic t_timer;
        op(K_LO, 8'h02);
        op(K_HI, 8'h00);
        op(K_MODE, 8'h0C);
        tone_gap(50, n);
        tone_gap(50, n);
        chk_val("fast period", 11'd3, n[10:0]);
        chk_bit("underflow flag", 1'b1, event_flags[EV_TMR_BIT]);
        op(K_MODE, 8'h0D);
        tone_gap(100, n);
        tone_gap(100, n);
        chk_val("slow period", 11'(3 * DIV), n[10:0]);
        op(K_HI, 8'h00);
        tone_gap(40, n);
        chk_val("halted gap", 11'd40, n[10:0]);
        op(K_MODE, 8'h0C);
        chk_bit("flag after run", 1'b0, event_flags[EV_TMR_BIT]);
        op(K_MODE, 8'h00);
        tone_wave = 1'b1;
        cyc(2);
        chk_bit("routed wave high", 1'b1, pin);
        tone_wave = 1'b0;
        cyc(2);
        chk_bit("routed wave low", 1'b0, pin);
    endtask : t_timer

    // timer source served at its vector, stack pushed, further requests inhibited
    task automatic t_irq_timer;
        op(K_IEF, 8'h80);
        op(K_MODE, 8'h08);
        cyc(6);
        chk_bit("timer irq", 1'b1, irq);
        chk_val("timer vector", VEC_TMR, vec);
        op(K_ACK, 8'h00);
        chk_bit("push", 1'b1, push);
        op(K_LO, 8'h02);
        chk_bit("inhibited", 1'b0, irq);
        op(K_MODE, 8'h08);
        cyc(5);
        op(K_EN, 8'h00);
        chk_bit("re-enabled", 1'b1, irq);
        op(K_DIS, 8'h00);
        chk_bit("disabled", 1'b0, irq);
        op(K_LO, 8'h02);
    endtask : t_irq_timer

    // divider beats port; acceptance clears one flag only
    task automatic t_priority;
        op(K_CLR, 8'hFF);
        op(K_PEF, 8'h01);
        op(K_IEF, 8'h85);
        div_ovf = 1'b1;
        port_chg = 4'h1;
        cyc(1);
        div_ovf = 1'b0;
        port_chg = 4'h0;
        chk_val("first vector", VEC_DIV, vec);
        op(K_ACK, 8'h00);
        chk_val("flags after ack", 11'h004, {3'b0, event_flags});
        op(K_EN, 8'h00);
        chk_val("second vector", VEC_PORT, vec);
        op(K_IEF, 8'h00);
        op(K_CLR, 8'hFF);
    endtask : t_priority

    // timer underflow releases hold; a set cause makes hold void
    task automatic t_hold;
        op(K_HEF, 8'h80);
        op(K_MODE, 8'h08);
        op(K_HOLD, 8'h00);
        chk_bit("held", 1'b1, hold);
        n = 0;
        while (hold === 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        chk_bit("released", 1'b0, hold);
        chk_bit("cause bit", 1'b1, hold_release_cause[CAUSE_TMR_BIT]);
        op(K_HOLD, 8'h00);
        chk_bit("hold void", 1'b0, hold);
        op(K_LO, 8'h02);
    endtask : t_hold

    // enabled falling wake pin ends stop
    task automatic t_stop;
        op(K_WAKE, 8'h01);
        op(K_STOP, 8'h00);
        chk_bit("stopped", 1'b1, stop);
        fall_req = 4'h1;
        n = 0;
        while (stop === 1'b1 && n < 12)
        begin
            cyc(1);
            n++;
        end
        fall_req = 4'h0;
        chk_bit("woken", 1'b0, stop);
    endtask : t_stop

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // watchdog: the tests need well under a thousand cycles
    initial
    begin
        #(50 * 5000);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        instr = '0;
        div_ovf = 1'b0;
        port_chg = 4'h0;
        fall_req = 4'h0;
        tone_wave = 1'b0;
        repeat (3) @(posedge clk);
        #2 rst = 1'b0;
        t_reset();
        t_timer();
        t_irq_timer();
        t_priority();
        t_hold();
        t_stop();
        tally_and_finish();
    end
endmodule : rth_reload_timer_irq_hold_ctrl_tb_top

// >>> rth_wake_model.sv
/*
 * behavioural model of the external wake-up pins on the far side of the block.
 * assumes the bench requests a falling edge by raising a request bit; pins idle
 * high because the wake port carries a pull-up while nothing pulls it down.
 */
`timescale 1ns/1ps

module rth_wake_model (
    input  wire logic       i_clk,          // system clock, used only to pace edges
    input  wire logic [3:0] i_fall_req,     // per-pin request to pull low
    output logic      [3:0] o_wake_pins     // wake pins seen by the block
);
    // pins fall just after an edge and stay low while requested; released pins
    // return to the pull-up level, never to a stale driven value
    always @(posedge i_clk)
    begin
        o_wake_pins <= #2 ~i_fall_req;      // falling edge on request
    end

    initial o_wake_pins = 4'hF;             // idle at the pull-up level
endmodule : rth_wake_model
